// File: rtl/transient_detect_map.vh
// Register map, field positions, reset values and timing constants of the transient detector
`ifndef TRANSIENT_DETECT_MAP_VH
`define TRANSIENT_DETECT_MAP_VH
// Register indices; byte address is four times the index
`define REG_IDX_CONFIG        8'h1d
`define REG_IDX_SOURCE        8'h1e
`define REG_IDX_THRESHOLD     8'h1f
`define REG_IDX_DEBOUNCE      8'h20
`define REG_IDX_SAMPLE_MODE   8'h21
// Configuration fields
`define CFG_FILTER_BYPASS     0
`define CFG_X_ENABLE          1
`define CFG_Y_ENABLE          2
`define CFG_Z_ENABLE          3
`define CFG_LATCH_ENABLE      4
`define CFG_WRITE_MASK        8'h1f
// Source fields
`define SRC_X_POL             0
`define SRC_X_EVENT           1
`define SRC_Y_POL             2
`define SRC_Y_EVENT           3
`define SRC_Z_POL             4
`define SRC_Z_EVENT           5
`define SRC_ACTIVE            6
// Threshold fields
`define THS_DEBOUNCE_MODE     7
// Sample mode register fields: rate code [2:0], oversampling [4:3], low noise [5]
`define SMODE_LOW_NOISE       5
`define SMODE_WRITE_MASK      8'h3f
// Reset values
`define RESET_BYTE            8'h00
// Oversampling mode codes
`define OSM_NORMAL            2'h0
`define OSM_LOW_POWER_LOW_NOISE_OVERSAMPLING              2'h1
`define OSM_HIGH_RESOLUTION_OVERSAMPLING           2'h2
`define OSM_LP                2'h3
// Debounce step times in microseconds
`define STEP_1250_US          1250
`define STEP_2500_US          2500
`define STEP_5000_US          5000
`define STEP_10000_US         10000
`define STEP_20000_US         20000
`define STEP_80000_US         80000
`define STEP_160000_US        160000
// Clock in MHz; cycles = microseconds times MHz
`define CLK_MHZ               10
// Largest threshold count with low noise set (4 g at 0.063 g per count)
`define THS_LOW_NOISE_MAX     7'h3f
`endif

// File: rtl/transient_accel_detector.v
// Transient acceleration detector with AXI4-Lite register slave
`timescale 1ns/10ps
`include "transient_detect_map.vh"

module transient_accel_detector (
  input  wire        ref_clk_in,          // System clock, 10 MHz
  input  wire        reset_in,            // Synchronous reset, active high
  input  wire [11:0] x_filtered_in,       // High-pass X sample, signed 8 g scale
  input  wire [11:0] y_filtered_in,       // High-pass Y sample
  input  wire [11:0] z_filtered_in,       // High-pass Z sample
  input  wire [11:0] x_raw_in,            // Unfiltered X sample
  input  wire [11:0] y_raw_in,            // Unfiltered Y sample
  input  wire [11:0] z_raw_in,            // Unfiltered Z sample
  input  wire        int_enable_in,       // Transient interrupt enabled
  input  wire [7:0]  s_axi_awaddr,        // Write address
  input  wire        s_axi_awvalid,       // Write address valid
  output wire        s_axi_awready,       // Write address ready
  input  wire [31:0] s_axi_wdata,         // Write data
  input  wire [3:0]  s_axi_wstrb,         // Write strobes
  input  wire        s_axi_wvalid,        // Write data valid
  output wire        s_axi_wready,        // Write data ready
  output reg  [1:0]  s_axi_bresp,         // Write response
  output reg         s_axi_bvalid,        // Write response valid
  input  wire        s_axi_bready,        // Write response ready
  input  wire [7:0]  s_axi_araddr,        // Read address
  input  wire        s_axi_arvalid,       // Read address valid
  output wire        s_axi_arready,       // Read address ready
  output reg  [31:0] s_axi_rdata,         // Read data
  output reg  [1:0]  s_axi_rresp,         // Read response
  output reg         s_axi_rvalid,        // Read data valid
  input  wire        s_axi_rready,        // Read data ready
  output wire        transient_int_out,   // Pending transient interrupt
  output wire        sample_strobe_out    // Debounce step tick
);

  // Register state
  reg  [7:0]  config_q;                    // Configuration register
  reg  [7:0]  source_q;                    // Source register
  reg  [7:0]  threshold_q;                 // Threshold and debounce mode
  reg  [7:0]  debounce_count_q;            // Debounce target count
  reg  [7:0]  sample_mode_q;               // Rate, oversampling, low noise
  reg  [7:0]  axis_counter_q [0:2];        // Per-axis debounce counters
  reg  [2:0]  detect_q;                    // Debounced detection per axis
  reg  [2:0]  sign_q;                      // Sign at detection per axis
  reg  [20:0] step_timer_q;                // Step period counter
  reg         int_pending_q;               // Interrupt pending
  reg         update_q;                    // Detection state fresh from a step tick
  reg         aw_held_q;                   // Write address captured
  reg         w_held_q;                    // Write data captured
  reg  [7:0]  aw_addr_q;                   // Captured write address
  reg  [31:0] w_data_q;                    // Captured write data
  reg  [3:0]  w_strb_q;                    // Captured write strobes

  // Combinational helpers
  wire [11:0] sample_x;                    // Selected X sample
  wire [11:0] sample_y;                    // Selected Y sample
  wire [11:0] sample_z;                    // Selected Z sample
  wire [6:0]  threshold_eff;               // Threshold after low-noise clamp
  wire [2:0]  match;                       // Per-axis comparison result
  wire [2:0]  axis_enable;                 // Per-axis enables
  wire [20:0] step_cycles;                 // Current step length in cycles
  wire        step_tick;                   // One cycle per debounce step
  wire        write_fire;                  // Write performed this cycle
  wire        read_fire;                   // Read taken this cycle
  wire        source_read;                 // Read of the source register
  reg  [7:0]  source_d;                    // Next source value
  reg  [7:0]  read_byte;                   // Read mux result

  // Unsigned magnitude of a signed sample, saturating the most negative
  function [10:0] magnitude;
    input [11:0] s;
    reg   [11:0] n;
    begin
      n = ~s + 12'h001;
      if (!s[11]) begin
        magnitude = s[10:0];
      end else if (n[11]) begin
        magnitude = 11'h7ff;
      end else begin
        magnitude = n[10:0];
      end
    end
  endfunction

  // Compare magnitude against threshold; count is 1/128 of full 8 g sample scale
  function is_over;
    input [11:0] s;
    input [6:0]  t;
    begin
      is_over = (magnitude(s) > {t, 4'h0});
    end
  endfunction

  // Microseconds to cycles at the system clock
  function [20:0] us_to_cycles;
    input [31:0] us;
    reg   [31:0] c;
    begin
      c = us * `CLK_MHZ;
      us_to_cycles = c[20:0];
    end
  endfunction

  // Choose filtered or raw data
  assign sample_x = config_q[`CFG_FILTER_BYPASS] ? x_raw_in : x_filtered_in;
  assign sample_y = config_q[`CFG_FILTER_BYPASS] ? y_raw_in : y_filtered_in;
  assign sample_z = config_q[`CFG_FILTER_BYPASS] ? z_raw_in : z_filtered_in;

  // Low-noise mode clamps reachable threshold to 4 g
  assign threshold_eff = (sample_mode_q[`SMODE_LOW_NOISE] && threshold_q[6:0] > `THS_LOW_NOISE_MAX) ?
                         `THS_LOW_NOISE_MAX : threshold_q[6:0];

  assign match = {is_over(sample_z, threshold_eff), is_over(sample_y, threshold_eff),
                  is_over(sample_x, threshold_eff)};
  assign axis_enable = {config_q[`CFG_Z_ENABLE], config_q[`CFG_Y_ENABLE], config_q[`CFG_X_ENABLE]};

  // Step length from rate code (0 = 800 Hz .. 7 = 1.56 Hz) and oversampling mode
  assign step_cycles =
    (sample_mode_q[2:0] == 3'h0) ? us_to_cycles(`STEP_1250_US) :
    (sample_mode_q[2:0] == 3'h1) ? us_to_cycles(`STEP_2500_US) :
    (sample_mode_q[4:3] == `OSM_HIGH_RESOLUTION_OVERSAMPLING) ? us_to_cycles(`STEP_2500_US) :
    (sample_mode_q[2:0] == 3'h2) ? us_to_cycles(`STEP_5000_US) :
    (sample_mode_q[2:0] == 3'h3) ? us_to_cycles(`STEP_10000_US) :
    (sample_mode_q[2:0] == 3'h4 || sample_mode_q[4:3] == `OSM_NORMAL) ? us_to_cycles(`STEP_20000_US) :
    (sample_mode_q[4:3] == `OSM_LOW_POWER_LOW_NOISE_OVERSAMPLING || sample_mode_q[2:0] == 3'h5) ? us_to_cycles(`STEP_80000_US) :
    us_to_cycles(`STEP_160000_US);

  assign step_tick = (step_timer_q >= step_cycles - 21'h00_0001);
  assign sample_strobe_out = step_tick;

  // Step timer
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      step_timer_q <= 21'h00_0000;
    end else if (step_tick) begin
      step_timer_q <= 21'h00_0000;
    end else begin
      step_timer_q <= step_timer_q + 21'h00_0001;
    end
  end

  // Per-axis debounce counters and detection state
  integer i;
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      for (i = 0; i < 3; i = i + 1) begin
        axis_counter_q[i] <= 8'h00;
      end
      detect_q <= 3'h0;
      sign_q   <= 3'h0;
    end else if (step_tick) begin
      for (i = 0; i < 3; i = i + 1) begin
        if (!axis_enable[i]) begin
          // Disabled axis clears its counter and detection; sign_q keeps its value
          axis_counter_q[i] <= 8'h00;
          detect_q[i]       <= 1'b0;
        end else if (match[i]) begin
          // Saturate at the programmed count
          if (axis_counter_q[i] < debounce_count_q) begin
            axis_counter_q[i] <= axis_counter_q[i] + 8'h01;
          end
          // Nine bits so a count saturated at 255 still detects
          detect_q[i] <= ({1'b0, axis_counter_q[i]} + 9'h001 >= {1'b0, debounce_count_q});
          sign_q[i]   <= (i == 0) ? sample_x[11] : (i == 1) ? sample_y[11] : sample_z[11];
        end else begin
          detect_q[i] <= 1'b0;
          if (threshold_q[`THS_DEBOUNCE_MODE]) begin
            axis_counter_q[i] <= 8'h00;
          end else if (axis_counter_q[i] != 8'h00) begin
            axis_counter_q[i] <= axis_counter_q[i] - 8'h01;
          end
        end
      end
    end
  end

  // Marks the cycle after a step tick, when detection state is new
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      update_q <= 1'b0;
    end else begin
      update_q <= step_tick;
    end
  end

  // Next source value
  integer k;
  always @* begin
    source_d = source_q;
    if (config_q[`CFG_LATCH_ENABLE]) begin
      // Latched: only add events; polarity tracks new events
      for (k = 0; k < 3; k = k + 1) begin
        // Only a fresh step may latch, so a read is not undone next cycle
        if (update_q && detect_q[k] && axis_enable[k]) begin
          source_d[2*k+1] = 1'b1;
          source_d[2*k]   = sign_q[k];
        end
      end
    end else begin
      // Live: follow debounced state
      for (k = 0; k < 3; k = k + 1) begin
        source_d[2*k+1] = detect_q[k] & axis_enable[k];
        source_d[2*k]   = detect_q[k] & axis_enable[k] & sign_q[k];
      end
    end
    source_d[`SRC_ACTIVE] = source_d[`SRC_X_EVENT] | source_d[`SRC_Y_EVENT] | source_d[`SRC_Z_EVENT];
    source_d[7] = 1'b0;
  end

  // Source register and interrupt; clear on read (source only when latched), new event wins
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      source_q      <= `RESET_BYTE;
      int_pending_q <= 1'b0;
    end else begin
      if (source_read && (source_d == source_q || !config_q[`CFG_LATCH_ENABLE])) begin
        source_q <= config_q[`CFG_LATCH_ENABLE] ? `RESET_BYTE : source_d;
      end else begin
        source_q <= source_d;
      end
      if (source_d[`SRC_ACTIVE] && !source_q[`SRC_ACTIVE] && int_enable_in) begin
        int_pending_q <= 1'b1;
      end else if (source_read) begin
        int_pending_q <= 1'b0;
      end
    end
  end

  assign transient_int_out = int_pending_q;

  // AXI write channel capture, either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign write_fire    = aw_held_q && w_held_q;

  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (write_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped addresses answer SLVERR
        s_axi_bresp  <= (aw_addr_q[7:2] >= `REG_IDX_CONFIG && aw_addr_q[7:2] <= `REG_IDX_SAMPLE_MODE) ?
                        2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers; only the low byte lane matters
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      config_q         <= `RESET_BYTE;
      threshold_q      <= `RESET_BYTE;
      debounce_count_q <= `RESET_BYTE;
      sample_mode_q    <= `RESET_BYTE;
    end else if (write_fire && w_strb_q[0]) begin
      case (aw_addr_q[7:2])
        `REG_IDX_CONFIG:      config_q         <= w_data_q[7:0] & `CFG_WRITE_MASK;
        `REG_IDX_THRESHOLD:   threshold_q      <= w_data_q[7:0];
        `REG_IDX_DEBOUNCE:    debounce_count_q <= w_data_q[7:0];
        `REG_IDX_SAMPLE_MODE: sample_mode_q    <= w_data_q[7:0] & `SMODE_WRITE_MASK;
        default:              config_q         <= config_q;
      endcase
    end
  end

  // Read mux
  always @* begin
    case (s_axi_araddr[7:2])
      `REG_IDX_CONFIG:      read_byte = config_q;
      `REG_IDX_SOURCE:      read_byte = source_q;
      `REG_IDX_THRESHOLD:   read_byte = threshold_q;
      `REG_IDX_DEBOUNCE:    read_byte = debounce_count_q;
      `REG_IDX_SAMPLE_MODE: read_byte = sample_mode_q;
      default:              read_byte = 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign read_fire     = s_axi_arvalid && s_axi_arready;
  assign source_read   = read_fire && (s_axi_araddr[7:2] == `REG_IDX_SOURCE);

  // Read data channel
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (read_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, read_byte};
      s_axi_rresp  <= (s_axi_araddr[7:2] >= `REG_IDX_CONFIG && s_axi_araddr[7:2] <= `REG_IDX_SAMPLE_MODE) ?
                      2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // transient_accel_detector

// File: verification/transient_monitor.sv
// Checker for bus handshakes, step tick spacing and interrupt behaviour
`timescale 1ns/10ps
module transient_monitor (
  input wire logic        ref_clk_in,
  input wire logic        reset_in,
  input wire logic        int_enable_in,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        transient_int_out,
  input wire logic        sample_strobe_out
);
  logic [20:0] gap_q;   // Cycles since the last step tick
  logic        seen_q;  // A step tick has been seen
  logic [7:0]  addr_q;  // Address of the read under way
  // Tick spacing counter and read address capture
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      gap_q  <= 21'h00_0000;
      seen_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      gap_q  <= sample_strobe_out ? 21'h00_0001 : gap_q + 21'h00_0001;
      seen_q <= seen_q | sample_strobe_out;
      addr_q <= (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : addr_q;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during answer");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write ready early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read data not zero");
  a_active_summary: assert property (s_axi_rvalid && addr_q == 8'h78 |->
    !s_axi_rdata[7] && s_axi_rdata[6] == (s_axi_rdata[5] | s_axi_rdata[3] | s_axi_rdata[1]))
    else $error("source summary bit wrong");
  a_config_reserved: assert property (s_axi_rvalid && addr_q == 8'h74 |-> s_axi_rdata[7:5] == 3'h0)
    else $error("config reserved bits set");
  a_strobe_pulse: assert property (sample_strobe_out |=> !sample_strobe_out) else $error("tick too long");
  a_step_spacing: assert property (sample_strobe_out && seen_q |->
    gap_q inside {21'h00_30d4, 21'h00_61a8, 21'h00_c350, 21'h01_86a0, 21'h03_0d40, 21'h0c_3500, 21'h18_6a00})
    else $error("step spacing wrong");
  a_int_read_clear: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h78
    && gap_q > 21'h00_0008 |=> !transient_int_out) else $error("interrupt not cleared by read");
  a_int_enable: assert property ($rose(transient_int_out) |-> $past(int_enable_in) && gap_q <= 21'h00_0008)
    else $error("interrupt raised without cause");
  c_source_read: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h78);
  c_int_rise: cover property ($rose(transient_int_out));
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule  // transient_monitor
bind transient_accel_detector transient_monitor u_transient_monitor (.*);

// File: verification/accel_sample_feed.sv
// Sample pipeline stand-in presenting filtered and raw axis samples
`timescale 1ns/10ps
module accel_sample_feed (
  input  wire logic        ref_clk_in,   // System clock
  input  wire logic [35:0] filt_set_in,  // Filtered Z,Y,X samples to present
  input  wire logic [35:0] raw_set_in,   // Unfiltered Z,Y,X samples to present
  output logic      [35:0] filt_out,     // Filtered Z,Y,X samples
  output logic      [35:0] raw_out       // Unfiltered Z,Y,X samples
);
  // New samples appear on a clock edge and stay steady between
  always_ff @(posedge ref_clk_in) begin
    filt_out <= filt_set_in;
    raw_out  <= raw_set_in;
  end
endmodule  // accel_sample_feed

// File: verification/test_transient_accel_detector.sv
// Register-level tests of the transient acceleration detector
`timescale 1ns/10ps
module test_transient_accel_detector;
  logic        ref_clk_in, reset_in, int_enable_in;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata;
  logic        transient_int_out, sample_strobe_out;
  logic [11:0] x_filtered_in, y_filtered_in, z_filtered_in, x_raw_in, y_raw_in, z_raw_in;
  logic [35:0] filt_set, raw_set;  // Requested Z,Y,X samples
  int          fails, checks;
  logic [7:0]  regs [4] = '{8'h74, 8'h78, 8'h7c, 8'h80};  // Config, source, threshold, count
  transient_accel_detector u_transient_accel_detector (.*);
  accel_sample_feed u_accel_sample_feed (
    .ref_clk_in  (ref_clk_in),
    .filt_set_in (filt_set),
    .raw_set_in  (raw_set),
    .filt_out    ({z_filtered_in, y_filtered_in, x_filtered_in}),
    .raw_out     ({z_raw_in, y_raw_in, x_raw_in})
  );
  // Clock of 100 ns period
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus write; each item released at the rising edge that takes it
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
    logic aw_p, w_p, b;
    aw_p = 1'b1;
    w_p = 1'b1;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_p || w_p || !b) begin
      @(posedge ref_clk_in);
      b = s_axi_bvalid;
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // Bus read; data and response taken at the answering edge
  task automatic axi_read(input logic [7:0] a);
    logic p, v;
    p = 1'b1;
    v = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!v) begin
      @(posedge ref_clk_in);
      if (p && s_axi_arready) begin
        p = 1'b0;
        s_axi_arvalid <= 1'b0;
      end else if (!p && s_axi_rvalid) begin
        v = 1'b1;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
      end
    end
    s_axi_rready <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // Wait for a debounce step tick, then let the source settle
  task automatic wait_tick;
    logic s;
    s = 1'b0;
    while (!s) begin
      @(negedge ref_clk_in);
      s = sample_strobe_out;
      @(posedge ref_clk_in);
    end
    repeat (6) @(posedge ref_clk_in);
  endtask
  // Print the verdict and stop
  task automatic give_verdict;
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #10_000_000;
    fails++;
    give_verdict();
  end
  // Main test sequence
  initial begin
    {reset_in, int_enable_in} = 2'b11;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0_0000_0000_000f;
    {filt_set, raw_set} = 72'h00_0000_0000_0000_0000;
    fails = 0;
    checks = 0;
    repeat (20) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    foreach (regs[i]) begin
      axi_read(regs[i]);
      check("reset value", rd, 32'h0000_0000);
    end
    axi_read(8'h40);
    check("unmapped response", {30'h0, rs}, 32'h0000_0002);
    axi_write(8'h74, 8'hff);
    axi_read(8'h74);
    check("config readback", rd, 32'h0000_001f);
    axi_write(8'h80, 8'ha5);
    axi_read(8'h80);
    check("count readback", rd, 32'h0000_00a5);
    // Latched: X negative above, Y at threshold, Z disabled
    axi_write(8'h7c, 8'h10);
    axi_write(8'h80, 8'h00);
    axi_write(8'h74, 8'h16);
    filt_set <= {12'h3e8, 12'h100, 12'heff};
    wait_tick();
    check("interrupt raised", {31'h0, transient_int_out}, 32'h0000_0001);
    axi_read(8'h78);
    check("latched source", rd, 32'h0000_0043);
    check("interrupt after read", {31'h0, transient_int_out}, 32'h0000_0000);
    axi_read(8'h78);
    check("source after read", rd, 32'h0000_0000);
    // Second event adds Y; interrupt disabled
    filt_set <= {12'h3e8, 12'h101, 12'heff};
    int_enable_in <= 1'b0;
    wait_tick();
    check("interrupt disabled", {31'h0, transient_int_out}, 32'h0000_0000);
    axi_read(8'h78);
    check("accumulated source", rd, 32'h0000_004b);
    // Unlatched, bypass, clear mode, count of two
    axi_write(8'h74, 8'h03);
    axi_write(8'h7c, 8'h90);
    axi_read(8'h7c);
    check("threshold readback", rd, 32'h0000_0090);
    axi_write(8'h80, 8'h02);
    filt_set <= 36'h0_0000_0000;
    raw_set <= {24'h00_0000, 12'h12c};
    wait_tick();
    axi_read(8'h78);
    check("first match", rd, 32'h0000_0000);
    wait_tick();
    axi_read(8'h78);
    check("bypass event", rd, 32'h0000_0042);
    raw_set <= 36'h0_0000_0000;
    wait_tick();
    axi_read(8'h78);
    check("live source dropped", rd, 32'h0000_0000);
    give_verdict();
  end
endmodule  // test_transient_accel_detector
